// file: rtl/fss_pkg.sv
/*
  Package of the frame slip store block: register map, field positions,
  reset values, the register struct of the top and the structs carried between the top and the stores.
  Assumes a 32-bit classic Wishbone slave with one register per word.
*/
package fss_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] FSS_IDX_RX_CFG  = 8'h1c;
  localparam logic [7:0] FSS_IDX_RX_IRQ  = 8'h1d;
  localparam logic [7:0] FSS_IDX_RX_IDLE = 8'h1e;
  localparam logic [7:0] FSS_IDX_TX_CFG  = 8'h20;
  localparam logic [7:0] FSS_IDX_TX_IRQ  = 8'h21;
  localparam logic [7:0] FSS_ADR_RX_CFG  = {FSS_IDX_RX_CFG[5:0], 2'b00};
  localparam logic [7:0] FSS_ADR_RX_IRQ  = {FSS_IDX_RX_IRQ[5:0], 2'b00};
  localparam logic [7:0] FSS_ADR_RX_IDLE = {FSS_IDX_RX_IDLE[5:0], 2'b00};
  localparam logic [7:0] FSS_ADR_TX_CFG  = {FSS_IDX_TX_CFG[5:0], 2'b00};
  localparam logic [7:0] FSS_ADR_TX_IRQ  = {FSS_IDX_TX_IRQ[5:0], 2'b00};

  // Field positions
  localparam int FSS_CFG_RSV_BIT  = 7;
  localparam int FSS_CFG_IN_BIT   = 1;
  localparam int FSS_CFG_OUT_BIT  = 0;
  localparam int FSS_IRQ_EN_BIT   = 2;
  localparam int FSS_IRQ_DIR_BIT  = 1;
  localparam int FSS_IRQ_FLAG_BIT = 0;

  // Reset values
  localparam logic       FSS_RST_RSV  = 1'b0;
  localparam logic       FSS_RST_IN   = 1'b1;
  localparam logic       FSS_RST_OUT  = 1'b1;
  localparam logic       FSS_RST_EN   = 1'b0;
  localparam logic [7:0] FSS_RST_IDLE = 8'hff;

  // Frame geometry: timeslot index width, last timeslot index per layout, last bit index
  localparam int         FSS_SLOT_W  = 5;
  localparam logic [4:0] FSS_E1_LAST = 5'h1f;
  localparam logic [4:0] FSS_T1_LAST = 5'h17;
  localparam logic [2:0] FSS_BIT_LAST = 3'h7;

  typedef struct packed {
    logic cfg_reserved;
    logic in_layout_e1;
    logic out_layout_e1;
    logic slip_irq_enable;
    logic slip_direction;
    logic slip_event_flag;
  } fss_regs_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fss_byte_type;

  typedef struct packed {
    logic hit;
    logic deleted;
  } fss_slip_type;

endpackage

// file: rtl/fss_slip_store.sv
/*
  One frame slip store: a ring of whole frames written byte by byte on the
  input side and read byte by byte on the output side. A full ring drops the
  incoming frame, an empty ring replays the frame just read.
  Assumes read requests are at least two clocks apart.
*/
`timescale 1ns/1ns
`default_nettype none
module fss_slip_store
  import fss_pkg::*;
#(
  parameter int NFR = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_layout_e1_i,
  input  wire logic         out_layout_e1_i,
  input  wire fss_byte_type wr_i,
  input  wire logic         rd_req_i,
  output logic [7:0]        rd_data_o,
  output fss_slip_type      slip_o
);
  localparam int FW = $clog2(NFR);
  localparam int CW = FW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(NFR - 2);

  logic [7:0]            mem [NFR << FSS_SLOT_W];
  logic [FW-1:0]         wframe, next_wframe, rframe, next_rframe;
  logic [FSS_SLOT_W-1:0] wslot, next_wslot, rslot, next_rslot;
  logic [CW-1:0]         count, next_count, cnt_rd;
  fss_slip_type          next_slip;
  logic                  wr_end, rd_end;

  always_comb begin
    wr_end      = wr_i.valid && (wslot == (in_layout_e1_i ? FSS_E1_LAST : FSS_T1_LAST));
    rd_end      = rd_req_i && (rslot == (out_layout_e1_i ? FSS_E1_LAST : FSS_T1_LAST));
    next_wframe = wframe;
    next_rframe = rframe;
    next_wslot  = wslot;
    next_rslot  = rslot;
    next_slip   = '0;
    cnt_rd      = count;
    if (wr_i.valid) begin
      next_wslot = wr_end ? '0 : wslot + 1'b1;
    end
    if (rd_req_i) begin
      next_rslot = rd_end ? '0 : rslot + 1'b1;
    end
    if (rd_end) begin
      if (count != '0) begin
        next_rframe = rframe + 1'b1;
        cnt_rd      = count - 1'b1;
      end else begin
        next_slip = '{hit: 1'b1, deleted: 1'b0};
      end
    end
    next_count = cnt_rd;
    if (wr_end) begin
      if (count == FULL_CNT) begin
        next_slip = '{hit: 1'b1, deleted: 1'b1};
      end else begin
        next_wframe = wframe + 1'b1;
        next_count  = cnt_rd + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wframe <= '0;
      rframe <= '0;
      wslot  <= '0;
      rslot  <= '0;
      count  <= '0;
      slip_o <= '0;
    end else begin
      wframe <= next_wframe;
      rframe <= next_rframe;
      wslot  <= next_wslot;
      rslot  <= next_rslot;
      count  <= next_count;
      slip_o <= next_slip;
    end
  end

  // Frame storage; the writer starts one frame ahead of the reader
  always_ff @(posedge clk_i) begin
    if (wr_i.valid) begin
      mem[{FW'(wframe + 1'b1), wslot}] <= wr_i.data;
    end
    rd_data_o <= mem[{rframe, rslot}];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_DELETE_ON_FULL: assert property (wr_end && count == FULL_CNT |=> slip_o.hit && slip_o.deleted)
    else $error("full store did not delete a frame");
  AST_DUP_ON_EMPTY: assert property (rd_end && count == '0 |=> slip_o.hit && !slip_o.deleted)
    else $error("empty store did not duplicate a frame");
  AST_NO_SPURIOUS_SLIP: assert property (!wr_end && !rd_end |=> !slip_o.hit)
    else $error("slip without a frame boundary");
  CVR_DELETE: cover property (slip_o.hit && slip_o.deleted);
  CVR_DUP: cover property (slip_o.hit && !slip_o.deleted);
endmodule
`default_nettype wire

// file: rtl/fss_top.sv
/*
  Frame slip elastic stores, receive and transmit, with their Wishbone
  register file, slip interrupt and receive backplane serialiser.
  Assumes a 25 MHz clock, byte strobes from the framer and backplane logic,
  and a receive bit tick at least two clocks apart.
*/
// Implementation choice: register access over Wishbone.
// Summary of operation
// - An enabled slip of either store drives the shared interrupt low.
// - Reset clears the slip interrupt enable of both stores.
// - A full store deletes a frame and records direction one.
// - An empty store duplicates a frame and records direction zero.
// - Each slip sets the event flag, and a status register read clears it.
// - Out of frame with trunk conditioning, every receive timeslot is the idle code.
// - Reset loads the idle code with all ones.
// - The idle code leaves most significant bit first.
// - An idle code write affects at most one timeslot before it is used.
`timescale 1ns/1ns
`default_nettype none
module fss_top
  import fss_pkg::*;
#(
  parameter int NFR = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  output logic              interrupt_out_n_o,
  input  wire fss_byte_type rx_line_i,
  input  wire logic         rx_out_of_frame_i,
  input  wire logic         trunk_conditioning_enable_i,
  input  wire logic         rx_bit_tick_i,
  output logic              rx_backplane_serial_data_o,
  input  wire fss_byte_type tx_backplane_i,
  input  wire logic         tx_line_req_i,
  output logic [7:0]        tx_line_data_o
);
  fss_regs_type rx_regs, next_rx_regs, tx_regs, next_tx_regs;
  logic [7:0]   rx_idle_code, next_rx_idle_code;
  logic [31:0]  next_wb_dat;
  logic         next_wb_ack, next_irq_n;
  logic         wb_req, wb_wr, wb_rd;
  fss_slip_type rx_slip, tx_slip;
  logic [7:0]   rx_store_data;
  logic [2:0]   rx_bit_cnt, next_rx_bit_cnt;
  logic [7:0]   rx_shift, next_rx_shift, rx_load_byte;
  logic         next_rx_serial, rx_load, rx_idle_sel;

  // Register update for one store: configuration, enable and slip status
  function automatic fss_regs_type fss_update(input fss_regs_type r,
                                              input logic cfg_wr,
                                              input logic irq_wr,
                                              input logic irq_rd,
                                              input logic [7:0] d,
                                              input fss_slip_type s);
    fss_regs_type n;
    n = r;
    if (cfg_wr) begin
      n.cfg_reserved  = d[FSS_CFG_RSV_BIT];
      n.in_layout_e1  = d[FSS_CFG_IN_BIT];
      n.out_layout_e1 = d[FSS_CFG_OUT_BIT];
    end
    if (irq_wr) begin
      n.slip_irq_enable = d[FSS_IRQ_EN_BIT];
      if (d[FSS_IRQ_FLAG_BIT]) begin
        n.slip_event_flag = 1'b0;
      end
    end
    if (irq_rd) begin
      n.slip_event_flag = 1'b0;
    end
    // A slip in the same cycle as a clear still sets the flag
    if (s.hit) begin
      n.slip_event_flag = 1'b1;
      n.slip_direction  = s.deleted;
    end
    return n;
  endfunction

  function automatic logic [7:0] fss_cfg_byte(input fss_regs_type r);
    logic [7:0] b;
    b = 8'h00;
    b[FSS_CFG_RSV_BIT] = r.cfg_reserved;
    b[FSS_CFG_IN_BIT]  = r.in_layout_e1;
    b[FSS_CFG_OUT_BIT] = r.out_layout_e1;
    return b;
  endfunction

  function automatic logic [7:0] fss_irq_byte(input fss_regs_type r);
    logic [7:0] b;
    b = 8'h00;
    b[FSS_IRQ_EN_BIT]   = r.slip_irq_enable;
    b[FSS_IRQ_DIR_BIT]  = r.slip_direction;
    b[FSS_IRQ_FLAG_BIT] = r.slip_event_flag;
    return b;
  endfunction

  // Register bus: one wait state, unmapped reads return zero
  always_comb begin
    wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wb_wr       = wb_req && wb_we_i && wb_sel_i[0];
    wb_rd       = wb_req && !wb_we_i;
    next_wb_ack = wb_req;
    next_wb_dat = 32'h0000_0000;
    if (wb_rd) begin
      unique case (wb_adr_i)
        FSS_ADR_RX_CFG: next_wb_dat = {24'h000000, fss_cfg_byte(rx_regs)};
        FSS_ADR_RX_IRQ: next_wb_dat = {24'h000000, fss_irq_byte(rx_regs)};
        FSS_ADR_RX_IDLE: next_wb_dat = {24'h000000, rx_idle_code};
        FSS_ADR_TX_CFG: next_wb_dat = {24'h000000, fss_cfg_byte(tx_regs)};
        FSS_ADR_TX_IRQ: next_wb_dat = {24'h000000, fss_irq_byte(tx_regs)};
        default: next_wb_dat = 32'h0000_0000;
      endcase
    end
    next_rx_regs = fss_update(rx_regs, wb_wr && wb_adr_i == FSS_ADR_RX_CFG,
                              wb_wr && wb_adr_i == FSS_ADR_RX_IRQ,
                              wb_rd && wb_adr_i == FSS_ADR_RX_IRQ,
                              wb_dat_i[7:0], rx_slip);
    next_tx_regs = fss_update(tx_regs, wb_wr && wb_adr_i == FSS_ADR_TX_CFG,
                              wb_wr && wb_adr_i == FSS_ADR_TX_IRQ,
                              wb_rd && wb_adr_i == FSS_ADR_TX_IRQ,
                              wb_dat_i[7:0], tx_slip);
    next_rx_idle_code = rx_idle_code;
    if (wb_wr && wb_adr_i == FSS_ADR_RX_IDLE) begin
      next_rx_idle_code = wb_dat_i[7:0];
    end
    next_irq_n = !((rx_regs.slip_event_flag && rx_regs.slip_irq_enable) ||
                   (tx_regs.slip_event_flag && tx_regs.slip_irq_enable));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o          <= 1'b0;
      wb_dat_o          <= 32'h0000_0000;
      interrupt_out_n_o <= 1'b1;
      rx_idle_code      <= FSS_RST_IDLE;
      rx_regs           <= '{FSS_RST_RSV, FSS_RST_IN, FSS_RST_OUT, FSS_RST_EN, 1'b0, 1'b0};
      tx_regs           <= '{FSS_RST_RSV, FSS_RST_IN, FSS_RST_OUT, FSS_RST_EN, 1'b0, 1'b0};
    end else begin
      wb_ack_o          <= next_wb_ack;
      wb_dat_o          <= next_wb_dat;
      interrupt_out_n_o <= next_irq_n;
      rx_idle_code      <= next_rx_idle_code;
      rx_regs           <= next_rx_regs;
      tx_regs           <= next_tx_regs;
    end
  end

  fss_slip_store #(.NFR(NFR)) u_rx_store (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .in_layout_e1_i  (rx_regs.in_layout_e1),
    .out_layout_e1_i (rx_regs.out_layout_e1),
    .wr_i            (rx_line_i),
    .rd_req_i        (rx_load),
    .rd_data_o       (rx_store_data),
    .slip_o          (rx_slip)
  );

  fss_slip_store #(.NFR(NFR)) u_tx_store (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .in_layout_e1_i  (tx_regs.in_layout_e1),
    .out_layout_e1_i (tx_regs.out_layout_e1),
    .wr_i            (tx_backplane_i),
    .rd_req_i        (tx_line_req_i),
    .rd_data_o       (tx_line_data_o),
    .slip_o          (tx_slip)
  );

  // Receive serialiser: the timeslot byte is latched whole at its first bit
  always_comb begin
    rx_load         = rx_bit_tick_i && rx_bit_cnt == 3'h0;
    rx_idle_sel     = rx_out_of_frame_i && trunk_conditioning_enable_i;
    rx_load_byte    = rx_idle_sel ? rx_idle_code : rx_store_data;
    next_rx_bit_cnt = rx_bit_cnt;
    next_rx_shift   = rx_shift;
    next_rx_serial  = rx_backplane_serial_data_o;
    if (rx_bit_tick_i) begin
      next_rx_bit_cnt = (rx_bit_cnt == FSS_BIT_LAST) ? 3'h0 : rx_bit_cnt + 3'h1;
      if (rx_load) begin
        next_rx_serial = rx_load_byte[7];
        next_rx_shift  = {rx_load_byte[6:0], 1'b0};
      end else begin
        next_rx_serial = rx_shift[7];
        next_rx_shift  = {rx_shift[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_bit_cnt                 <= 3'h0;
      rx_shift                   <= 8'h00;
      rx_backplane_serial_data_o <= 1'b1;
    end else begin
      rx_bit_cnt                 <= next_rx_bit_cnt;
      rx_shift                   <= next_rx_shift;
      rx_backplane_serial_data_o <= next_rx_serial;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_IRQ_ASSERT: assert property (rx_regs.slip_event_flag && rx_regs.slip_irq_enable
                                   |=> !interrupt_out_n_o)
    else $error("enabled receive slip did not pull the interrupt low");
  AST_IRQ_MASKED: assert property (tx_slip.hit && !tx_regs.slip_irq_enable &&
                                   !rx_regs.slip_irq_enable && !wb_wr |=> ##1 interrupt_out_n_o)
    else $error("masked slip raised the interrupt");
  AST_ENABLE_RESET: assert property ($fell(rst_i) |-> !rx_regs.slip_irq_enable &&
                                     !tx_regs.slip_irq_enable)
    else $error("slip interrupt enable not cleared by reset");
  AST_DIR_RECORD: assert property (rx_slip.hit |=> rx_regs.slip_event_flag &&
                                   rx_regs.slip_direction == $past(rx_slip.deleted))
    else $error("slip direction or flag not recorded");
  AST_FLAG_READ_CLEAR: assert property (wb_rd && wb_adr_i == FSS_ADR_RX_IRQ && !rx_slip.hit
                                        |=> !rx_regs.slip_event_flag ##1
                                        (interrupt_out_n_o || tx_regs.slip_event_flag))
    else $error("status read did not clear the flag and release the interrupt");
  AST_IDLE_SUBST: assert property (rx_load && rx_idle_sel |=>
                                   rx_backplane_serial_data_o == $past(rx_idle_code[7]) &&
                                   rx_shift == {$past(rx_idle_code[6:0]), 1'b0})
    else $error("idle code not substituted msb first");
  AST_IDLE_RESET: assert property ($fell(rst_i) |-> rx_idle_code == FSS_RST_IDLE)
    else $error("idle code not all ones after reset");
  AST_SLOT_STABLE: assert property (rx_bit_tick_i && !rx_load |=>
                                    rx_shift == {$past(rx_shift[6:0]), 1'b0})
    else $error("timeslot changed in mid shift");
  CVR_IRQ_LOW: cover property ($fell(interrupt_out_n_o));
  CVR_IDLE_SLOT: cover property (rx_load && rx_idle_sel);
  CVR_READ_CLEAR: cover property (wb_rd && wb_adr_i == FSS_ADR_RX_IRQ && rx_regs.slip_event_flag);
endmodule
`default_nettype wire

// file: verification/fss_partner.sv
/*
  Far-side model of the slip stores: receive framer bytes, backplane bit
  ticks, transmit backplane bytes and transmit line byte requests.
  Assumes the bench sets the enables and the slow pace between clock edges.
*/
`timescale 1ns/1ns
`default_nettype none
module fss_partner
  import fss_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  input  wire logic    slow_i,
  input  wire logic    rx_on_i,
  input  wire logic    tick_on_i,
  input  wire logic    tx_on_i,
  input  wire logic    req_on_i,
  output fss_byte_type rx_line_o,
  output logic         tick_o,
  output fss_byte_type tx_bp_o,
  output logic         req_o
);
  integer     seed = 63053;
  logic [1:0] phase;
  logic       go;

  // Ticks and requests never closer than two clocks
  assign go = slow_i ? (phase == 2'h0) : !phase[0];

  // Data changes every clock, so a byte without valid is never stale
  always @(posedge clk_i) begin
    phase     <= rst_i ? 2'h0 : phase + 2'h1;
    rx_line_o <= {!rst_i && rx_on_i && !phase[0], 8'($random(seed))};
    tx_bp_o   <= {!rst_i && tx_on_i && !phase[0], 8'($random(seed))};
    tick_o    <= !rst_i && tick_on_i && go;
    req_o     <= !rst_i && req_on_i && go;
  end
endmodule
`default_nettype wire

// file: verification/fss_top_tb.sv
/*
  Self-checking bench of the frame slip stores: register map, idle code
  serialiser and slip interrupt of both stores.
  Assumes the far-side model in fss_partner and a 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module fss_top_tb
  import fss_pkg::*;
;
  logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]   wb_adr_i, q, tx_line_data_o, exp_code;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o;
  logic         interrupt_out_n_o, rx_out_of_frame_i, trunk_conditioning_enable_i;
  logic         rx_bit_tick_i, rx_backplane_serial_data_o, tx_line_req_i;
  fss_byte_type rx_line_i, tx_backplane_i;
  logic         slow, rx_on, tick_on, tx_on, req_on, mon_on, tick_q, exp_bit;
  logic [2:0]   bit_cnt;
  logic         exp_q[$];
  int           failures, n_tests, n_ticks, lows;
  integer       seed = 63053;
  logic [7:0]   adrs[6] = '{8'h70, 8'h74, 8'h78, 8'h80, 8'h84, 8'h7c};
  logic [7:0]   rstv[6] = '{8'h03, 8'h00, 8'hff, 8'h03, 8'h00, 8'h00};
  localparam int NFR = 4;
  localparam int TSL = int'(FSS_T1_LAST) + 1;
  logic [7:0]   cur[TSL], wbuf[TSL];
  logic [7:0]   frm_q[$];
  logic         cur_ok;
  int           wsl, rsl, nfr;

  fss_top #(.NFR(NFR)) fss_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .interrupt_out_n_o(interrupt_out_n_o), .rx_line_i(rx_line_i),
    .rx_out_of_frame_i(rx_out_of_frame_i),
    .trunk_conditioning_enable_i(trunk_conditioning_enable_i),
    .rx_bit_tick_i(rx_bit_tick_i), .rx_backplane_serial_data_o(rx_backplane_serial_data_o),
    .tx_backplane_i(tx_backplane_i), .tx_line_req_i(tx_line_req_i),
    .tx_line_data_o(tx_line_data_o));

  fss_partner fss_partner_inst (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .rx_on_i(rx_on), .tick_on_i(tick_on), .tx_on_i(tx_on), .req_on_i(req_on),
    .rx_line_o(rx_line_i), .tick_o(rx_bit_tick_i), .tx_bp_o(tx_backplane_i),
    .req_o(tx_line_req_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rchk(input logic [7:0] adr, input logic [7:0] ex);
    wb(1'b0, adr, 8'h00);
    `CHK("register read", ex, q)
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (interrupt_out_n_o !== lvl && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("interrupt_out_n_o", lvl, interrupt_out_n_o)
  endtask

  task automatic wait_ticks(input int n);
    int t;
    t = n_ticks + n;
    while (n_ticks < t) @(posedge clk_i);
  endtask

  // Expected serial bits are queued one whole timeslot at a time
  always @(posedge clk_i) tick_q <= rx_bit_tick_i & ~rst_i;
  always @(negedge clk_i) begin
    if (rst_i) begin
      bit_cnt = 3'h0;
      n_ticks = 0;
    end else if (tick_q) begin
      if (mon_on && bit_cnt == 3'h0)
        for (int i = 7; i >= 0; i--) exp_q.push_back(exp_code[i]);
      if (exp_q.size() > 0) begin
        exp_bit = exp_q.pop_front();
        `CHK("rx_backplane_serial_data_o", exp_bit, rx_backplane_serial_data_o)
      end
      bit_cnt++;
      n_ticks++;
    end
  end

  // Transmit store model: whole T1 frames, dropped when full, replayed when empty
  always @(posedge clk_i) begin
    if (rst_i) begin
      cur_ok = 1'b0;
      wsl = 0;
      rsl = 0;
      frm_q.delete();
    end else begin
      nfr = frm_q.size() / TSL;
      if (tx_line_req_i) begin
        if (cur_ok) `CHK("tx_line_data_o", cur[rsl], tx_line_data_o)
        rsl++;
        if (rsl == TSL) begin
          rsl = 0;
          if (nfr > 0) begin
            cur_ok = 1'b1;
            foreach (cur[i]) cur[i] = frm_q.pop_front();
          end
        end
      end
      if (tx_backplane_i.valid) begin
        wbuf[wsl] = tx_backplane_i.data;
        wsl++;
        if (wsl == TSL) begin
          wsl = 0;
          if (nfr < NFR - 2) foreach (wbuf[i]) frm_q.push_back(wbuf[i]);
        end
      end
    end
  end

  initial begin
    #4_000_000;
    failures++;
    stop_test();
  end

  initial begin
    {rst_i, rx_out_of_frame_i, trunk_conditioning_enable_i} = 3'b100;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {slow, rx_on, tick_on, tx_on, req_on, mon_on} = '0;
    {failures, n_tests} = '0;
    exp_code = 8'hff;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (adrs[i]) rchk(adrs[i], rstv[i]);
    wb(1'b1, 8'h7c, 8'h55);
    rchk(8'h7c, 8'h00);
    wb(1'b1, FSS_ADR_TX_CFG, 8'h00);
    rchk(FSS_ADR_TX_CFG, 8'h00);
    wb(1'b1, FSS_ADR_RX_CFG, 8'h02);
    rchk(FSS_ADR_RX_CFG, 8'h02);
    wb(1'b1, FSS_ADR_RX_CFG, 8'h03);
    $display("test registers done");
    slow <= 1'($random(seed));
    rx_out_of_frame_i <= 1'b1;
    trunk_conditioning_enable_i <= 1'b1;
    tick_on <= 1'b1;
    mon_on <= 1'b1;
    wait_ticks(24);
    mon_on <= 1'b0;
    exp_code = 8'($random(seed));
    wb(1'b1, FSS_ADR_RX_IDLE, exp_code);
    rchk(FSS_ADR_RX_IDLE, exp_code);
    wait_ticks(16);
    mon_on <= 1'b1;
    wait_ticks(32);
    mon_on <= 1'b0;
    $display("test idle code done");
    wb(1'b1, FSS_ADR_RX_IRQ, 8'h04);
    wait_irq(1'b0);
    tick_on <= 1'b0;
    wait_ticks(0);
    repeat (12) @(posedge clk_i);
    rchk(FSS_ADR_RX_IRQ, 8'h05);
    `CHK("interrupt_out_n_o", 1'b1, interrupt_out_n_o)
    $display("test receive slip done");
    slow <= 1'($random(seed));
    wb(1'b1, FSS_ADR_TX_IRQ, 8'h04);
    req_on <= 1'b1;
    wait_irq(1'b0);
    req_on <= 1'b0;
    repeat (6) @(posedge clk_i);
    rchk(FSS_ADR_TX_IRQ, 8'h05);
    `CHK("interrupt_out_n_o", 1'b1, interrupt_out_n_o)
    tx_on <= 1'b1;
    wait_irq(1'b0);
    tx_on <= 1'b0;
    repeat (6) @(posedge clk_i);
    rchk(FSS_ADR_TX_IRQ, 8'h07);
    `CHK("interrupt_out_n_o", 1'b1, interrupt_out_n_o)
    $display("test transmit slips done");
    wb(1'b1, FSS_ADR_TX_IRQ, 8'h00);
    wb(1'b1, FSS_ADR_RX_IRQ, 8'h00);
    req_on <= 1'b1;
    rx_on <= 1'b1;
    lows = 0;
    repeat (800) begin
      @(posedge clk_i);
      if (interrupt_out_n_o !== 1'b1) lows++;
    end
    req_on <= 1'b0;
    rx_on <= 1'b0;
    `CHK("masked interrupt cycles", 0, lows)
    repeat (6) @(posedge clk_i);
    rchk(FSS_ADR_TX_IRQ, 8'h01);
    rchk(FSS_ADR_RX_IRQ, 8'h03);
    req_on <= 1'b1;
    repeat (300) @(posedge clk_i);
    req_on <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b1, FSS_ADR_TX_IRQ, 8'h01);
    rchk(FSS_ADR_TX_IRQ, 8'h00);
    $display("test mask and clear done");
    wb(1'b1, FSS_ADR_RX_IRQ, 8'h04);
    wb(1'b1, FSS_ADR_RX_IDLE, 8'h3c);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(FSS_ADR_RX_IRQ, 8'h00);
    rchk(FSS_ADR_RX_IDLE, 8'hff);
    rchk(FSS_ADR_TX_CFG, 8'h03);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
`default_nettype wire
